/* File: logic/eep_pkg.sv */
// Purpose: Shared constants of the serial nonvolatile memory command port.
// Assumes: One system clock at 25 MHz; serial pins already synchronous to it.
// Notes:   Opcode and sub-code values follow the instruction frame layout.
package eep_pkg;

  localparam logic [1:0] OP_EXT        = 2'h0;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_ERASE      = 2'h3;
  // Sub-codes carried in the top two address bits of OP_EXT.
  localparam logic [1:0] EXT_LOCK      = 2'h0;
  localparam logic [1:0] EXT_FILL      = 2'h1;
  localparam logic [1:0] EXT_CLEAR     = 2'h2;
  localparam logic [1:0] EXT_UNLOCK    = 2'h3;

  // Header bits after the start bit: opcode plus address.
  localparam logic [4:0] HDR_BITS_X16  = 5'h08;
  localparam logic [4:0] HDR_BITS_X8   = 5'h09;
  localparam logic [4:0] DATA_BITS_X16 = 5'h10;
  localparam logic [4:0] DATA_BITS_X8  = 5'h08;

  localparam int         ARRAY_BITS    = 1024;
  localparam int         BYTE_COUNT    = ARRAY_BITS / 8;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;

  // Queued program command: width flag, opcode, address, data.
  localparam int         CMD_W         = 1 + 2 + 7 + 16;
  localparam int         CMD_DEPTH     = 16;

  localparam int         CLK_HZ        = 25_000_000;
  localparam int         PROG_TIME_MS  = 10;
  localparam int         PROG_CYCLES   = CLK_HZ / 1000 * PROG_TIME_MS;
  localparam int         TIMER_W       = 24;

endpackage : eep_pkg

/* File: logic/eep_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Full and empty come from an occupancy count, so both are exact.
module eep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,     // System clock.
  input  wire logic             rst_n_i,   // Synchronous reset, active low.
  input  wire logic             in_valid_i, // Write request.
  output logic                  in_ready_o, // Not full.
  input  wire logic [WIDTH-1:0] in_data_i, // Write data.
  output logic                  out_valid_o, // Not empty.
  input  wire logic             out_ready_i, // Read acknowledge.
  output logic [WIDTH-1:0]      out_data_o // Head of queue.
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];
  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_ready_i && out_valid_o;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        store[wr_ptr] <= in_data_i;
        wr_ptr        <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end

endmodule : eep_fifo

/* File: logic/eep_port.sv */
// Purpose: Serial command port and array of a 1024-bit nonvolatile memory.
// Assumes: Serial pins are synchronous to clk_i; serial clock is sampled.
// Notes:   Program commands queue in a FIFO and run one per timed cycle.
module eep_port
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input  wire logic clk_i,             // System clock, 25 MHz.
  input  wire logic rst_n_i,           // Synchronous reset, active low.
  input  wire logic chip_select_i,     // Chip select, active high.
  input  wire logic serial_clock_in_i, // Serial clock, sampled.
  input  wire logic serial_in_line_i,  // Serial data in.
  input  wire logic word_width_strap_i, // 1 selects 16-bit words, 0 bytes.
  output logic      serial_out_o,      // Serial data out level.
  output logic      serial_out_oe_o,   // Drive enable of serial data out.
  output logic      busy_o             // Program cycle queued or running.
);

  typedef enum logic [2:0] {S_IDLE, S_HDR, S_DATA, S_READ, S_DONE} eep_state_e;

  typedef struct packed {
    eep_state_e           st;
    logic                 sk_q;
    logic [4:0]           cnt;
    logic [15:0]          sh;
    logic                 x8;
    logic [1:0]           op;
    logic [6:0]           addr;
    logic [15:0]          data;
    logic [15:0]          out_sr;
    logic                 complete;
    logic                 unlocked;
    logic                 status_show;
    logic                 hz_pend;
    logic                 dout;
    logic                 doe;
    logic                 push;
    logic                 eng_act;
    logic                 commit;
    logic [CMD_W-1:0]     cmd;
    logic [TIMER_W-1:0]   timer;
    logic                 busy;
  } eep_state_s;

  eep_state_s       r;
  eep_state_s       next_r;
  logic [7:0]       mem [BYTE_COUNT];
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [CMD_W-1:0] fifo_out_data;
  logic             pop;

  // Program instructions are those that need the self-timed cycle.
  function automatic logic is_program(input logic [1:0] op, input logic [1:0] sub);
    is_program = (op == OP_WRITE) || (op == OP_ERASE) ||
                 ((op == OP_EXT) && ((sub == EXT_FILL) || (sub == EXT_CLEAR)));
  endfunction : is_program

  function automatic logic [1:0] sub_code(input logic x8, input logic [6:0] addr);
    sub_code = x8 ? addr[6:5] : addr[5:4];
  endfunction : sub_code

  assign pop = !r.eng_act && fifo_out_valid;

  always_comb
  begin
    logic       sk_rise;
    logic       sk_fall;
    logic [15:0] nsh;
    logic [6:0]  na;
    logic [4:0]  hlen;
    logic [4:0]  dlen;
    logic [1:0]  sub;
    sk_rise = 1'b0;
    sk_fall = 1'b0;
    nsh     = '0;
    na      = '0;
    hlen    = '0;
    dlen    = '0;
    sub     = '0;
    next_r        = r;
    next_r.push   = 1'b0;
    next_r.commit = 1'b0;
    next_r.sk_q   = serial_clock_in_i;
    sk_rise = serial_clock_in_i && !r.sk_q;
    sk_fall = !serial_clock_in_i && r.sk_q;
    nsh     = {r.sh[14:0], serial_in_line_i};
    hlen    = r.x8 ? HDR_BITS_X8 : HDR_BITS_X16;
    dlen    = r.x8 ? DATA_BITS_X8 : DATA_BITS_X16;
    na      = r.x8 ? nsh[6:0] : {1'b0, nsh[5:0]};
    sub     = sub_code(r.x8, na);

    if (!chip_select_i)
    begin
      next_r.st       = S_IDLE;
      next_r.doe      = 1'b0;
      next_r.complete = 1'b0;
      next_r.hz_pend  = 1'b0;
      if (r.complete && r.unlocked && fifo_in_ready &&
          is_program(r.op, sub_code(r.x8, r.addr)))
      begin
        next_r.push        = 1'b1;
        next_r.status_show = 1'b1;
      end
    end
    else
    begin
      if (sk_rise)
      begin
        case (r.st)
          S_IDLE:
          begin
            if (serial_in_line_i)
            begin
              next_r.st  = S_HDR;
              next_r.cnt = '0;
              next_r.sh  = '0;
              next_r.x8  = !word_width_strap_i;
              if (r.status_show)
                next_r.hz_pend = 1'b1;
            end
          end
          S_HDR:
          begin
            next_r.sh  = nsh;
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt + 5'h01 == hlen)
            begin
              next_r.op   = nsh[hlen-5'h01 -: 2];
              next_r.addr = na;
              next_r.cnt  = '0;
              next_r.sh   = '0;
              next_r.st   = S_DONE;
              case (nsh[hlen-5'h01 -: 2])
                OP_READ:
                begin
                  next_r.st     = S_READ;
                  next_r.doe    = 1'b1;
                  next_r.dout   = 1'b0;
                  next_r.out_sr = r.x8 ? {mem[na], 8'h00} : {mem[{na[5:0], 1'b1}], mem[{na[5:0], 1'b0}]};
                end
                OP_WRITE:
                  next_r.st = S_DATA;
                OP_ERASE:
                  next_r.complete = 1'b1;
                default:
                begin
                  case (sub)
                    EXT_FILL:   next_r.st = S_DATA;
                    EXT_CLEAR:  next_r.complete = 1'b1;
                    EXT_UNLOCK: next_r.unlocked = 1'b1;
                    EXT_LOCK:   next_r.unlocked = 1'b0;
                    default:    next_r.unlocked = r.unlocked;
                  endcase
                end
              endcase
            end
          end
          S_DATA:
          begin
            next_r.sh  = nsh;
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt + 5'h01 == dlen)
            begin
              next_r.data     = r.x8 ? {8'h00, nsh[7:0]} : nsh;
              next_r.complete = 1'b1;
              next_r.st       = S_DONE;
            end
          end
          S_READ:
          begin
            next_r.dout   = r.out_sr[15];
            next_r.out_sr = {r.out_sr[14:0], 1'b0};
          end
          S_DONE:
            // A clock after the last bit means select came too late: drop it.
            next_r.complete = 1'b0;
          default:
            next_r.st = S_IDLE;
        endcase
      end
      if (sk_fall && r.hz_pend)
      begin
        next_r.hz_pend     = 1'b0;
        next_r.status_show = 1'b0;
        next_r.doe         = 1'b0;
      end
      else if (r.status_show && !r.hz_pend && r.st == S_IDLE)
      begin
        next_r.doe  = 1'b1;
        next_r.dout = !r.busy;
      end
    end

    if (pop)
    begin
      next_r.eng_act = 1'b1;
      next_r.cmd     = fifo_out_data;
      next_r.timer   = TIMER_W'(PROG_CYCLES_P - 1);
    end
    else if (r.eng_act)
    begin
      if (r.timer == '0)
      begin
        next_r.eng_act = 1'b0;
        next_r.commit  = 1'b1;
      end
      else
        next_r.timer = r.timer - 1'b1;
    end
    next_r.busy = next_r.eng_act || fifo_out_valid || next_r.push || r.push;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      r          <= '0;
      r.st       <= S_IDLE;
      r.sk_q     <= 1'b1;
      r.unlocked <= 1'b0;
    end
    else
      r <= next_r;
  end

  eep_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (CMD_DEPTH)
  ) u_cmd_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (r.push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({r.x8, r.op, r.addr, r.data}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

  // Array contents are nonvolatile, so reset leaves them alone.
  genvar gi;
  generate
    for (gi = 0; gi < BYTE_COUNT; gi++)
    begin : g_byte
      logic       c_x8;
      logic [1:0] c_op;
      logic [6:0] c_addr;
      logic [15:0] c_data;
      logic       all;
      logic       hit;
      logic       erase;
      logic [7:0] val;
      assign {c_x8, c_op, c_addr, c_data} = r.cmd;
      assign all   = (c_op == OP_EXT);
      assign erase = (c_op == OP_ERASE) || (all && sub_code(c_x8, c_addr) == EXT_CLEAR);
      assign hit   = all || (c_x8 ? (c_addr == 7'(gi)) : (c_addr[5:0] == 6'(gi / 2)));
      assign val   = erase ? ERASED_BYTE :
                     ((!c_x8 && (gi % 2 == 1)) ? c_data[15:8] : c_data[7:0]);
      always_ff @(posedge clk_i)
      begin
        if (r.commit && hit)
          mem[gi] <= val;
      end
    end
  endgenerate

  assign serial_out_o    = r.dout;
  assign serial_out_oe_o = r.doe;
  assign busy_o          = r.busy;

endmodule : eep_port

/* File: dv/eep_port_properties.sv */
// Purpose: Pin timing properties of the serial memory command port.
// Assumes: Serial clock phases last at least two system clocks.
// Notes:   Latencies allow one spare clock where the hand-over leaves it open.
module eep_port_properties #(
  parameter int PROG_CYCLES_P = 20
) (
  input wire logic clk_i,             // System clock.
  input wire logic rst_n_i,           // Synchronous reset, active low.
  input wire logic chip_select_i,     // Chip select.
  input wire logic serial_clock_in_i, // Serial clock.
  input wire logic serial_out_o,      // Data out level.
  input wire logic serial_out_oe_o,   // Data out enable.
  input wire logic busy_o             // Program busy.
);
  logic [31:0] busy_cnt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Counts how long busy has stood, so a short program cycle shows up.
  always_ff @(posedge clk_i)
    busy_cnt <= (!rst_n_i || !busy_o) ? 32'h0 : busy_cnt + 32'h1;

  a_reset_quiet: assert property ($rose(rst_n_i) |-> !serial_out_oe_o && !busy_o)
    else $error("outputs active after reset");
  a_oe_needs_select: assert property (!chip_select_i ##1 !chip_select_i |=> !serial_out_oe_o)
    else $error("output driven while deselected");
  a_oe_rise_select: assert property ($rose(serial_out_oe_o) |-> $past(chip_select_i))
    else $error("output enabled without select");
  a_busy_on_launch: assert property ($rose(busy_o) |-> !$past(chip_select_i))
    else $error("busy rose without select falling");
  a_busy_min_time: assert property ($fell(busy_o) |-> busy_cnt >= PROG_CYCLES_P)
    else $error("program cycle too short");
  a_out_on_rise: assert property (serial_out_oe_o && $past(serial_out_oe_o) && $changed(serial_out_o)
    |-> $past(serial_clock_in_i) && (!$past(serial_clock_in_i, 2) || !$past(serial_clock_in_i, 3))
    || $past(busy_o, 2) != busy_o)
    else $error("output bit changed off a serial rise");
  a_oe_drop_cause: assert property ($fell(serial_out_oe_o) |-> !$past(rst_n_i) || !$past(chip_select_i)
    || !$past(serial_clock_in_i) && ($past(serial_clock_in_i, 2) || $past(serial_clock_in_i, 3)))
    else $error("output released off a serial fall");
  a_first_bit_sane: assert property ($rose(serial_out_oe_o) |-> !(serial_out_o && busy_o))
    else $error("first driven bit high while busy");

  c_launch: cover property ($rose(busy_o));
  c_release: cover property ($fell(serial_out_oe_o) && chip_select_i);
  c_read: cover property ($rose(serial_out_oe_o) && !serial_out_o);
endmodule : eep_port_properties

bind eep_port eep_port_properties #(.PROG_CYCLES_P(PROG_CYCLES_P)) eep_port_properties_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_i(chip_select_i), .serial_clock_in_i(serial_clock_in_i),
  .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .busy_o(busy_o));

/* File: dv/eep_host_model.sv */
// Purpose: Serial master that frames instructions for the memory port.
// Assumes: Every change lands one time unit after a clock rise.
// Notes:   Serial clock rests low between frames.
module eep_host_model (
  input  wire logic clk_i, // System clock.
  input  wire logic out_i, // Data out level.
  input  wire logic oe_i,  // Data out enable.
  output logic      cs_o,  // Chip select.
  output logic      sck_o, // Serial clock.
  output logic      di_o   // Serial data in.
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    cs_o = 1'b0;
    sck_o = 1'b0;
    di_o = 1'b0;
  end

  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // Samples the line late in the high phase, after the bit has settled.
  task bit_cyc(input logic b, output logic [1:0] s);
    di_o = b;
    tick(2);
    sck_o = 1'b1;
    tick(2);
    s = {oe_i, out_i};
    sck_o = 1'b0;
    tick(3);
  endtask : bit_cyc

  task xfer(input logic [31:0] bits, input int n, output logic [31:0] got);
    logic [1:0] s;
    got = '0;
    tick(1);
    cs_o = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      bit_cyc(bits[i], s);
      got = {got[30:0], s[1] ? s[0] : 1'b1};
    end
    di_o = ~di_o;
    cs_o = 1'b0;
    tick(2);
  endtask : xfer

  task stat(output logic [1:0] s);
    tick(1);
    cs_o = 1'b1;
    tick(2);
    s = {oe_i, out_i};
  endtask : stat

  task idle;
    cs_o = 1'b0;
    tick(2);
  endtask : idle
endmodule : eep_host_model

/* File: dv/eep_port_tb.sv */
// Purpose: Self-checking bench for the serial memory command port.
// Assumes: Program cycle shortened to a few clocks for simulation.
// Notes:   Each scenario task drives frames and judges the replies itself.
module eep_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import eep_pkg::*;
  localparam int PROG_P = 20;
  localparam int POWERUP_WAIT = 25000;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        strap = 1'b1;
  logic        cs, sck, di, sout, soe, busy;
  logic [31:0] got;
  logic [1:0]  st;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;

  always #20 clk = ~clk;

  eep_port #(.PROG_CYCLES_P(PROG_P)) eep_port_i (.clk_i(clk), .rst_n_i(rst_n), .chip_select_i(cs),
    .serial_clock_in_i(sck), .serial_in_line_i(di), .word_width_strap_i(strap), .serial_out_o(sout),
    .serial_out_oe_o(soe), .busy_o(busy));
  eep_host_model eep_host_model_i (.clk_i(clk), .out_i(sout), .oe_i(soe), .cs_o(cs), .sck_o(sck), .di_o(di));

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy time", 32'(n <= PROG_P + 4), 32'h1);
  endtask : wait_idle

  task prog(input logic [31:0] bits, input int n, input logic launch);
    eep_host_model_i.xfer(bits, n, got);
    chk("busy", 32'(busy), 32'(launch));
    wait_idle();
  endtask : prog

  // In 25- and 18-bit frames the first captured bit of the kept slice is the dummy zero.
  task rd(input logic [31:0] bits, input int n, input int w, input logic [31:0] exp);
    eep_host_model_i.xfer(bits, n, got);
    chk("read", got & ((32'h1 << w) - 32'h1), exp);
  endtask : rd

  task t_reset;
    chk("idle oe", 32'(soe), 32'h0);
    chk("idle busy", 32'(busy), 32'h0);
    repeat (POWERUP_WAIT) @(posedge clk);
    #1;
    prog({1'b1, OP_WRITE, 6'h03, 16'h0000}, 25, 1'b0);
  endtask : t_reset

  task t_rw16;
    prog({1'b1, OP_EXT, EXT_UNLOCK, 4'h0}, 9, 1'b0);
    eep_host_model_i.xfer({1'b1, OP_WRITE, 6'h03, 16'ha5c3}, 25, got);
    eep_host_model_i.stat(st);
    chk("status busy", 32'(st), 32'h2);
    eep_host_model_i.idle();
    wait_idle();
    eep_host_model_i.stat(st);
    chk("status ready", 32'(st), 32'h3);
    // A clocked-in 1 ends status display for good, so the release comes last.
    eep_host_model_i.bit_cyc(1'b1, st);
    chk("status hold", 32'(st), 32'h3);
    chk("status release", 32'(soe), 32'h0);
    eep_host_model_i.idle();
    rd({1'b1, OP_READ, 6'h03, 16'h0}, 28, 17, 32'ha5c3);
  endtask : t_rw16

  task t_bytes;
    strap = 1'b0;
    rd({1'b1, OP_READ, 7'h06, 8'h0}, 18, 9, 32'hc3);
    prog({1'b1, OP_WRITE, 7'h07, 8'h5a}, 18, 1'b1);
    strap = 1'b1;
    rd({1'b1, OP_READ, 6'h03, 16'h0}, 25, 17, 32'h5ac3);
  endtask : t_bytes

  task t_erase;
    prog({1'b1, OP_ERASE, 6'h03}, 9, 1'b1);
    rd({1'b1, OP_READ, 6'h03, 16'h0}, 25, 17, 32'hffff);
    prog({1'b1, OP_EXT, EXT_FILL, 4'h0, 16'h1234}, 25, 1'b1);
    rd({1'b1, OP_READ, 6'h3f, 16'h0}, 25, 17, 32'h1234);
    prog({1'b1, OP_EXT, EXT_CLEAR, 4'h0}, 9, 1'b1);
    rd({1'b1, OP_READ, 6'h00, 16'h0}, 25, 17, 32'hffff);
    prog({1'b1, OP_EXT, EXT_LOCK, 4'h0}, 9, 1'b0);
    prog({1'b1, OP_WRITE, 6'h00, 16'h0}, 25, 1'b0);
    rd({1'b1, OP_READ, 6'h00, 16'h0}, 25, 17, 32'hffff);
  endtask : t_erase

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      end_sim();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_rw16();
    t_bytes();
    t_erase();
    end_sim();
  end
endmodule : eep_port_tb
